/* File: inc/bbf_consts.vh */
// Constants for the two-way bus-matching FIFO
`ifndef BBF_CONSTS_VH
`define BBF_CONSTS_VH
`define BBF_WORD_W        36
`define BBF_ADDR_W        14
`define BBF_OFF_DEF_8     16'h0008
`define BBF_OFF_DEF_16    16'h0010
`define BBF_OFF_DEF_64    16'h0040
`define BBF_OFF_DEF_256   16'h0100
`define BBF_OFF_DEF_1024  16'h0400
`define BBF_FS_8          3'h0
`define BBF_FS_16         3'h1
`define BBF_FS_64         3'h2
`define BBF_FS_256        3'h3
`define BBF_FS_1024       3'h4
`define BBF_FS_SERIAL     3'h5
`define BBF_FS_PARALLEL   3'h6
`define BBF_SIZE_36       2'h0
`define BBF_SIZE_18       2'h1
`define BBF_SIZE_9        2'h2
`define BBF_PARITY_BIT    8
`endif

/* File: logic/bbf_bidir_fifo.v */
// Two-way clocked FIFO pair with Port B bus matching, mailboxes and flags
// Notes on behaviour
// RULE1 - Two 36-bit FIFOs, opposite directions, deep
// RULE2 - Port B moves 36, 18 or 9 bits
// RULE3 - Transfers only on clock edge with enables
// RULE4 - Same-edge read and write handled correctly
// RULE5 - Two mailboxes bypass FIFOs, Port B width
// RULE6 - Mailbox flag set when new word written
// RULE7 - Master reset clears pointers, latches configuration
// RULE8 - Partial reset clears pointers, keeps configuration
// RULE9 - Retransmit rewinds read pointer only
// RULE10 - Retransmit mode turns partial reset into retransmit
// RULE11 - Standard mode needs read for first word
// RULE12 - Fall-through shows first word without read
// RULE13 - Mode input level selects timing mode
// RULE14 - Flags mean empty/full or ready by mode
// RULE15 - Programmable almost-empty and almost-full flags
// RULE16 - Full passes three flops, almost-full two
// RULE17 - Empty and almost-empty pass two flops
// RULE18 - Offsets load parallel or serial per setup
// RULE19 - Flag select picks default offset or method
// RULE20 - Interspersed parity ignores data bit eight
// RULE21 - Idle low power, wake on any control
// RULE22 - Almost-empty low when words at most offset
// RULE23 - Almost-full low when free at most offset
// RULE24 - Simultaneous read and write keeps fill level
`timescale 1ns/1ps
`include "bbf_consts.vh"

// One FIFO: storage, pointers, timing modes, retransmit and flags
module bbf_fifo_core #(
  parameter DW = `BBF_WORD_W,
  parameter AW = `BBF_ADDR_W
) (
  input  wire          clk,
  input  wire          reset,
  input  wire          flushReq,
  input  wire          rewindReq,
  input  wire          fall_through_mode,
  input  wire          wrEn,
  input  wire [DW-1:0] wrData,
  input  wire          rdEn,
  input  wire [AW-1:0] aeOffset,
  input  wire [AW-1:0] afOffset,
  output wire          wrReady,
  output wire          rdReady,
  output reg  [DW-1:0] rdData,
  output reg           notFullSync,
  output reg           notEmptySync,
  output reg           almostEmptyNSync,
  output reg           almostFullNSync
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  reg  [DW-1:0] mem [0:(1<<AW)-1]; // Storage in flip-flops
  reg  [AW-1:0] wrPtr;
  reg  [AW-1:0] rdPtr;
  reg  [AW:0]   count;             // Words held in storage
  reg           outValid;          // Output register holds a word
  reg  [3:0]    flagStage1;        // First synchroniser stage
  wire          memEmpty = (count == {(AW+1){1'b0}});
  wire          memFull  = (count == DEPTH);
  wire          doWrite  = wrEn & ~memFull; // RULE3
  // Standard: each read fetches; fall-through: refill when output free
  wire          doLoad   = fall_through_mode ? (~memEmpty & (~outValid | rdEn)) // RULE12
                                : (rdEn & ~memEmpty);               // RULE11
  wire [AW:0]   level    = count + {{AW{1'b0}}, fall_through_mode & outValid};
  wire [AW:0]   freeSlot = DEPTH - level;
  wire [3:0]    flagRaw;

  assign wrReady = ~memFull;
  assign rdReady = fall_through_mode ? outValid : ~memEmpty;
  // Polarity is the same in both modes: high means usable
  assign flagRaw[0] = ~memFull;                         // RULE14
  assign flagRaw[1] = fall_through_mode ? outValid : ~memEmpty;      // RULE14
  assign flagRaw[2] = level > {1'b0, aeOffset};         // RULE22
  assign flagRaw[3] = freeSlot > {1'b0, afOffset};      // RULE23

  // Storage write, no reset needed on the array
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= wrData;
    end
  end

  // Pointers and fill level
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      rdData   <= {DW{1'b0}};
    end else if (flushReq) begin
      // Both pointers back to the first location
      wrPtr    <= {AW{1'b0}};  // RULE8
      rdPtr    <= {AW{1'b0}};  // RULE8
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
    end else if (rewindReq) begin
      // Only the read side moves; data stays put. Wrapped data is lost.
      rdPtr    <= {AW{1'b0}};  // RULE9
      count    <= memFull ? DEPTH : {1'b0, wrPtr}; // RULE9
      outValid <= 1'b0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doLoad) begin
        rdPtr  <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
        rdData <= mem[rdPtr];
      end
      // Both on one edge leaves the level alone
      if (doWrite & ~doLoad) begin  // RULE4 RULE24
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (doLoad & ~doWrite) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
      // Output register valid tracking
      if (doLoad) begin
        outValid <= 1'b1;
      end else if (rdEn) begin
        outValid <= 1'b0;
      end
    end
  end

  // Two-stage flag synchronisers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flagStage1       <= 4'h0;
      notFullSync      <= 1'b0;
      notEmptySync     <= 1'b0;
      almostEmptyNSync <= 1'b0;
      almostFullNSync  <= 1'b0;
    end else begin
      flagStage1       <= flagRaw;
      notFullSync      <= flagStage1[0]; // RULE16
      almostFullNSync  <= flagStage1[3]; // RULE16
      notEmptySync     <= flagStage1[1]; // RULE17
      almostEmptyNSync <= flagStage1[2]; // RULE17
    end
  end
endmodule // bbf_fifo_core

// Top: two FIFOs, bus matching, mailboxes, offsets and power state
module bbf_bidir_fifo #(
  parameter AW = `BBF_ADDR_W
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        masterResetOneN,
  input  wire        masterResetTwoN,
  input  wire        partialResetFifoOneN,
  input  wire        partialResetFifoTwoN,
  input  wire        retransmitModeSelect,
  input  wire        endianTimingModeSelect,
  input  wire        paritySelect,
  input  wire        flagSelectBit0,
  input  wire        flagSelectBit1,
  input  wire        flagSelectBit2,
  input  wire        serialOffsetInput,
  input  wire        offsetLoadEnable,
  input  wire [1:0]  portBSize,
  input  wire [35:0] portADataBus,
  input  wire        portAWriteEnable,
  input  wire        portAReadEnable,
  input  wire        portAMailSelect,
  output wire [35:0] portADataOut,
  input  wire [35:0] portBDataIn,
  input  wire        portBWriteEnable,
  input  wire        portBReadEnable,
  input  wire        portBMailSelect,
  output wire [35:0] portBDataOut,
  output reg         portAFullInReady,
  output reg         portBFullInReady,
  output wire        portAEmptyOutReady,
  output wire        portBEmptyOutReady,
  output wire        portAAlmostEmptyN,
  output wire        portBAlmostEmptyN,
  output wire        portAAlmostFullN,
  output wire        portBAlmostFullN,
  output reg         mailboxOneFlag,
  output reg         mailboxTwoFlag,
  output reg         lowPowerIdle
);
  reg  [2:0]    flagSel;         // Latched flag programming choice
  reg           bigEndian;       // Latched byte order
  reg           parityOn;        // Latched interspersed parity
  reg  [AW-1:0] offAe1;          // Almost-empty, FIFO1 at Port B
  reg  [AW-1:0] offAf1;          // Almost-full, FIFO1 at Port A
  reg  [AW-1:0] offAe2;          // Almost-empty, FIFO2 at Port A
  reg  [AW-1:0] offAf2;          // Almost-full, FIFO2 at Port B
  reg  [1:0]    progIdx;         // Next offset for parallel loading
  reg  [35:0]   mailOne;         // Mailbox A to B
  reg  [35:0]   mailTwo;         // Mailbox B to A
  reg  [35:0]   bufData0;        // Two-entry input buffer, head
  reg  [35:0]   bufData1;        // Two-entry input buffer, tail
  reg  [1:0]    bufCount;
  reg  [1:0]    bPiece;          // Piece counter for Port B reads
  reg  [1:0]    bShow;           // Piece shown on Port B output in standard mode
  reg  [1:0]    bInPiece;        // Piece counter for Port B writes
  reg  [35:0]   bAcc;            // Assembly of narrow Port B writes
  wire          mrOne  = ~masterResetOneN;
  wire          mrTwo  = ~masterResetTwoN;
  wire          fall_through_mode   = endianTimingModeSelect;   // RULE13
  // Shared pin: retransmit when mode selected, else partial reset
  wire          rtOne  = ~partialResetFifoOneN & retransmitModeSelect;  // RULE10
  wire          rtTwo  = ~partialResetFifoTwoN & retransmitModeSelect;  // RULE10
  wire          prsOne = ~partialResetFifoOneN & ~retransmitModeSelect; // RULE8
  wire          prsTwo = ~partialResetFifoTwoN & ~retransmitModeSelect; // RULE8
  wire [1:0]    lastPiece = (portBSize == `BBF_SIZE_18) ? 2'h1 :
                            (portBSize == `BBF_SIZE_9)  ? 2'h3 : 2'h0;
  wire [5:0]    pieceW = (portBSize == `BBF_SIZE_18) ? 6'd18 :
                         (portBSize == `BBF_SIZE_9)  ? 6'd9 : 6'd36;
  wire [35:0]   widthMask = (portBSize == `BBF_SIZE_18) ? 36'h00003ffff :
                            (portBSize == `BBF_SIZE_9)  ? 36'h0000001ff : 36'hfffffffff;
  wire [1:0]    outIdx = fall_through_mode ? bPiece : bShow;
  wire [1:0]    outPos = bigEndian ? (lastPiece - outIdx) : outIdx;   // RULE2
  wire [1:0]    inPos  = bigEndian ? (lastPiece - bInPiece) : bInPiece;
  wire [35:0]   inPlaced = (portBDataIn & widthMask) << (pieceW * inPos);
  wire [35:0]   f1Data;
  wire [35:0]   f2Data;
  wire          f1WrReady;
  wire          f1RdReady;
  wire          f2WrReady;
  wire          f2RdReady;
  wire          f1NotFull;
  wire          f2NotFull;
  wire          bufPush = portAWriteEnable & ~portAMailSelect & (bufCount != 2'h2);
  wire          bufPop  = (bufCount != 2'h0) & f1WrReady;
  wire          bRd     = portBReadEnable & ~portBMailSelect & f1RdReady;
  wire          bWr     = portBWriteEnable & ~portBMailSelect & f2WrReady;
  wire          f1Rd    = bRd & (fall_through_mode ? (bPiece == lastPiece) : (bPiece == 2'h0));
  wire          f2Wr    = bWr & (bInPiece == lastPiece);
  wire [35:0]   parWide = parityOn ?
                          {1'b0, portADataBus[35:`BBF_PARITY_BIT+1], portADataBus[7:0]} :
                          portADataBus;                                 // RULE20
  wire [AW-1:0] parData = parWide[AW-1:0];
  wire          serialMode = (flagSel == `BBF_FS_SERIAL);
  wire          parMode    = (flagSel == `BBF_FS_PARALLEL);
  reg  [15:0]   defOffset;
  wire [AW-1:0] defCut = defOffset[AW-1:0];

  // Default offset chosen by the flag select code
  always @* begin
    case (flagSel)
      `BBF_FS_8:    defOffset = `BBF_OFF_DEF_8;    // RULE19
      `BBF_FS_16:   defOffset = `BBF_OFF_DEF_16;
      `BBF_FS_64:   defOffset = `BBF_OFF_DEF_64;
      `BBF_FS_256:  defOffset = `BBF_OFF_DEF_256;
      `BBF_FS_1024: defOffset = `BBF_OFF_DEF_1024;
      default:      defOffset = `BBF_OFF_DEF_8;
    endcase
  end

  // Narrow Port B views of the stored words
  assign portBDataOut = portBMailSelect ? (mailOne & widthMask) :
                        ((f1Data >> (pieceW * outPos)) & widthMask);
  assign portADataOut = portAMailSelect ? mailTwo : f2Data;

  // Configuration latched while either master reset is held
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flagSel   <= `BBF_FS_8;
      bigEndian <= 1'b0;
      parityOn  <= 1'b0;
      progIdx   <= 2'h0;
      offAe1    <= {AW{1'b0}};
      offAf1    <= {AW{1'b0}};
      offAe2    <= {AW{1'b0}};
      offAf2    <= {AW{1'b0}};
    end else if (mrOne | mrTwo) begin
      flagSel   <= {flagSelectBit2, flagSelectBit1, flagSelectBit0}; // RULE7
      bigEndian <= endianTimingModeSelect;                           // RULE7
      parityOn  <= paritySelect;
      progIdx   <= 2'h0;
      offAe1    <= defCut;
      offAf1    <= defCut;
      offAe2    <= defCut;
      offAf2    <= defCut;
    end else if (offsetLoadEnable & serialMode) begin
      // One bit per edge shifted through all four offsets
      {offAe1, offAf1, offAe2, offAf2} <=
        {offAe1[AW-2:0], offAf1, offAe2, offAf2, serialOffsetInput}; // RULE18
    end else if (offsetLoadEnable & parMode) begin
      progIdx <= progIdx + 2'h1;
      case (progIdx)
        2'h0:    offAe1 <= parData;  // RULE18
        2'h1:    offAf1 <= parData;
        2'h2:    offAe2 <= parData;
        default: offAf2 <= parData;
      endcase
    end
  end

  // Buffer between Port A writer and FIFO1; full buffer stalls Port A
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      bufCount <= 2'h0;
      bufData0 <= 36'h000000000;
      bufData1 <= 36'h000000000;
    end else if (mrOne | prsOne) begin
      bufCount <= 2'h0;
    end else begin
      if (bufPop) begin
        bufData0 <= (bufCount == 2'h2) ? bufData1 : portADataBus;
      end else if (bufPush & (bufCount == 2'h0)) begin
        bufData0 <= portADataBus;
      end
      if (bufPush & ((bufCount == 2'h1 & ~bufPop) | bufCount == 2'h2)) begin
        bufData1 <= portADataBus;
      end
      bufCount <= bufCount + {1'b0, bufPush} - {1'b0, bufPop};
    end
  end

  // Port B piece counters for bus matching
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      bPiece   <= 2'h0;
      bShow    <= 2'h0;
      bInPiece <= 2'h0;
      bAcc     <= 36'h000000000;
    end else begin
      if (mrOne | prsOne | rtOne) begin
        bPiece <= 2'h0;
      end else if (bRd) begin
        bShow  <= bPiece;
        bPiece <= (bPiece == lastPiece) ? 2'h0 : bPiece + 2'h1;  // RULE2
      end
      if (mrTwo | prsTwo) begin
        bInPiece <= 2'h0;
        bAcc     <= 36'h000000000;
      end else if (bWr) begin
        bInPiece <= (bInPiece == lastPiece) ? 2'h0 : bInPiece + 2'h1;
        bAcc     <= (bInPiece == 2'h0) ? inPlaced : (bAcc | inPlaced);
      end
    end
  end

  // Mailboxes; a new word beats a same-edge clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mailOne        <= 36'h000000000;
      mailTwo        <= 36'h000000000;
      mailboxOneFlag <= 1'b0;
      mailboxTwoFlag <= 1'b0;
    end else begin
      if (portAWriteEnable & portAMailSelect) begin
        mailOne        <= portADataBus & widthMask;   // RULE5
        mailboxOneFlag <= 1'b1;                       // RULE6
      end else if (mrOne | (portBReadEnable & portBMailSelect)) begin
        mailboxOneFlag <= 1'b0;
      end
      if (portBWriteEnable & portBMailSelect) begin
        mailTwo        <= portBDataIn & widthMask;    // RULE5
        mailboxTwoFlag <= 1'b1;                       // RULE6
      end else if (mrTwo | (portAReadEnable & portAMailSelect)) begin
        mailboxTwoFlag <= 1'b0;
      end
    end
  end

  // Write-side ready flags; Port A also sees the buffer state
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      portAFullInReady <= 1'b0;
      portBFullInReady <= 1'b0;
      lowPowerIdle     <= 1'b0;
    end else begin
      portAFullInReady <= f1NotFull & (bufCount != 2'h2);  // RULE16
      portBFullInReady <= f2NotFull;                       // RULE16
      // Any enable or reset pin wakes the device on the next edge
      lowPowerIdle <= ~(portAWriteEnable | portAReadEnable | portBWriteEnable |
                        portBReadEnable | offsetLoadEnable | mrOne | mrTwo |
                        ~partialResetFifoOneN | ~partialResetFifoTwoN);  // RULE21
    end
  end

  // FIFO1 carries Port A to Port B
  bbf_fifo_core #(.DW(36), .AW(AW)) fifoOne (  // RULE1
    .clk              (clk),
    .reset            (reset),
    .flushReq         (mrOne | prsOne),        // RULE7
    .rewindReq        (rtOne),
    .fall_through_mode             (fall_through_mode),
    .wrEn             (bufCount != 2'h0),
    .wrData           (bufData0),
    .rdEn             (f1Rd),
    .aeOffset         (offAe1),                // RULE15
    .afOffset         (offAf1),
    .wrReady          (f1WrReady),
    .rdReady          (f1RdReady),
    .rdData           (f1Data),
    .notFullSync      (f1NotFull),
    .notEmptySync     (portBEmptyOutReady),
    .almostEmptyNSync (portBAlmostEmptyN),
    .almostFullNSync  (portAAlmostFullN)
  );

  // FIFO2 carries Port B to Port A
  bbf_fifo_core #(.DW(36), .AW(AW)) fifoTwo (  // RULE1
    .clk              (clk),
    .reset            (reset),
    .flushReq         (mrTwo | prsTwo),        // RULE7
    .rewindReq        (rtTwo),
    .fall_through_mode             (fall_through_mode),
    .wrEn             (f2Wr),
    .wrData           (bAcc | inPlaced),
    .rdEn             (portAReadEnable & ~portAMailSelect), // RULE3
    .aeOffset         (offAe2),                // RULE15
    .afOffset         (offAf2),
    .wrReady          (f2WrReady),
    .rdReady          (f2RdReady),
    .rdData           (f2Data),
    .notFullSync      (f2NotFull),
    .notEmptySync     (portAEmptyOutReady),
    .almostEmptyNSync (portAAlmostEmptyN),
    .almostFullNSync  (portBAlmostFullN)
  );
endmodule // bbf_bidir_fifo

/* File: test/bbf_bidir_fifo_chk.sv */
// Port-level checker for the two-way bus-matching FIFO
`timescale 1ns/1ps
module bbf_bidir_fifo_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        masterResetOneN,
  input wire logic        masterResetTwoN,
  input wire logic        partialResetFifoOneN,
  input wire logic        partialResetFifoTwoN,
  input wire logic        retransmitModeSelect,
  input wire logic        endianTimingModeSelect,
  input wire logic        portAWriteEnable,
  input wire logic        portAMailSelect,
  input wire logic        portBWriteEnable,
  input wire logic        portBReadEnable,
  input wire logic        portBMailSelect,
  input wire logic [1:0]  portBSize,
  input wire logic [35:0] portBDataOut,
  input wire logic        portAEmptyOutReady,
  input wire logic        portBEmptyOutReady,
  input wire logic        portAAlmostEmptyN,
  input wire logic        portBAlmostEmptyN,
  input wire logic        mailboxOneFlag,
  input wire logic        mailboxTwoFlag,
  input wire logic        lowPowerIdle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Flush held long enough for the three-edge flag lag
  sequence flushOne;
    (!partialResetFifoOneN && !retransmitModeSelect && !portAWriteEnable)[*6];
  endsequence
  sequence flushTwo;
    (!partialResetFifoTwoN && !retransmitModeSelect && !portBWriteEnable)[*6];
  endsequence
  // Standard mode, nothing written into FIFO two for a while
  sequence quietTwo;
    (!portBWriteEnable && partialResetFifoTwoN && masterResetTwoN && !endianTimingModeSelect)[*8];
  endsequence
  mail_one_set_a: assert property (
    portAWriteEnable && portAMailSelect && masterResetOneN |=> mailboxOneFlag)
    else $error("mailbox one flag not set");
  mail_two_set_a: assert property (
    portBWriteEnable && portBMailSelect && masterResetTwoN |=> mailboxTwoFlag)
    else $error("mailbox two flag not set");
  mail_two_clr_a: assert property (
    !masterResetTwoN && !(portBWriteEnable && portBMailSelect) |=> !mailboxTwoFlag)
    else $error("mailbox two flag survived master reset");
  wake_on_write_a: assert property (
    portAWriteEnable || portBWriteEnable |=> !lowPowerIdle)
    else $error("idle shown after a write");
  flush_one_a: assert property (
    flushOne |-> !portBEmptyOutReady && !portBAlmostEmptyN)
    else $error("fifo one not empty after flush");
  flush_two_a: assert property (
    flushTwo |-> !portAEmptyOutReady && !portAAlmostEmptyN)
    else $error("fifo two not empty after flush");
  stay_empty_a: assert property (
    quietTwo ##0 !portAEmptyOutReady |=> !portAEmptyOutReady)
    else $error("fifo two ready without a write");
  hold_out_a: assert property (
    $past(!endianTimingModeSelect && !portBReadEnable && !portBMailSelect && masterResetOneN
    && partialResetFifoOneN) && !portBMailSelect && $stable(portBSize) |-> $stable(portBDataOut))
    else $error("port B output moved without a read");
endmodule // bbf_bidir_fifo_chk

bind bbf_bidir_fifo bbf_bidir_fifo_chk bbf_bidir_fifo_chk_i (.*);

/* File: test/bbf_port_b_reader.sv */
// Port B reader model: pops FIFO one words with a chosen pause
`timescale 1ns/1ps
module bbf_port_b_reader (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [5:0]  count,
  input  wire logic [3:0]  gap,
  input  wire logic        portBEmptyOutReady,
  input  wire logic [35:0] portBDataOut,
  output logic             portBReadEnable,
  output logic             done
);
  logic [35:0] got [0:31]; // Words taken, in order
  integer      n;          // Words taken so far
  // Reads only while data is flagged
  initial begin
    portBReadEnable = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge start);
      done = 1'b0;
      n = 0;
      while (n < count) begin
        @(negedge clk);
        if (portBEmptyOutReady) begin
          portBReadEnable = 1'b1;
          @(negedge clk);
          portBReadEnable = 1'b0;
          got[n] = portBDataOut;
          n = n + 1;
          repeat (gap) @(negedge clk);
        end
      end
      done = 1'b1;
    end
  end
endmodule // bbf_port_b_reader

/* File: test/bbf_bidir_fifo_tb.sv */
// Self-checking bench for the two-way bus-matching FIFO
`timescale 1ns/1ps
`include "bbf_consts.vh"
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module bbf_bidir_fifo_tb;
  logic        clk, reset, masterResetOneN, masterResetTwoN, partialResetFifoOneN;
  logic        partialResetFifoTwoN, retransmitModeSelect, endianTimingModeSelect, paritySelect;
  logic        flagSelectBit0, flagSelectBit1, flagSelectBit2, serialOffsetInput;
  logic        offsetLoadEnable, portAWriteEnable, portAReadEnable, portAMailSelect;
  logic        portBWriteEnable, portBReadEnable, portBMailSelect, portAFullInReady;
  logic        portBFullInReady, portAEmptyOutReady, portBEmptyOutReady, portAAlmostEmptyN;
  logic        portBAlmostEmptyN, portAAlmostFullN, portBAlmostFullN, mailboxOneFlag;
  logic        mailboxTwoFlag, lowPowerIdle, start, done;
  logic [1:0]  portBSize;
  logic [35:0] portADataBus, portBDataIn, portADataOut, portBDataOut;
  logic [5:0]  count;
  logic [3:0]  gap;
  integer      num_errors, tests_run, cycles;

  // Small depth keeps the fill test short
  bbf_bidir_fifo #(.AW(4)) bbf_bidir_fifo_i (.*);
  bbf_port_b_reader bbf_port_b_reader_i (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog against a hung handshake
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step(input integer n);
    repeat (n) @(negedge clk);
  endtask

  // Master reset, default offset 8
  task automatic mres(input logic be);
    {masterResetOneN, masterResetTwoN, endianTimingModeSelect} = {2'h0, be};
    {flagSelectBit2, flagSelectBit1, flagSelectBit0} = `BBF_FS_8;
    step(3);
    {masterResetOneN, masterResetTwoN, endianTimingModeSelect} = 3'h6;
    step(4);
  endtask

  task automatic wrA(input logic [35:0] d, input logic mail);
    {portADataBus, portAMailSelect, portAWriteEnable} = {d, mail, 1'b1};
    step(1);
    {portAMailSelect, portAWriteEnable} = 2'h0;
    step(1);
  endtask

  task automatic wrB(input logic [35:0] d, input logic mail);
    {portBDataIn, portBMailSelect, portBWriteEnable} = {d, mail, 1'b1};
    step(1);
    {portBMailSelect, portBWriteEnable} = 2'h0;
    step(1);
  endtask

  // Partner pops n words, bounded wait
  task automatic popB(input integer n, input integer g);
    integer t;
    {count, gap, start} = {n[5:0], g[3:0], 1'b1};
    step(1);
    start = 1'b0;
    for (t = 0; t < 400 && !done; t++) step(1);
  endtask

  // Partial reset of one FIFO, held past the flag lag
  task automatic prs(input logic two);
    {partialResetFifoOneN, partialResetFifoTwoN} = two ? 2'h2 : 2'h1;
    step(7);
    {partialResetFifoOneN, partialResetFifoTwoN} = 2'h3;
    step(4);
    `CHK(two ? portAEmptyOutReady : portBEmptyOutReady, 1'b0, "flush left data")
  endtask

  // Standard read path, then retransmit replays the same words
  task automatic t_stdret;
    integer j;
    integer r;
    for (j = 0; j < 3; j++) wrA(36'h5_0a0a_0000 + j, 1'b0);
    step(6);
    `CHK(portBEmptyOutReady, 1'b1, "fifo one not ready")
    `CHK(lowPowerIdle, 1'b1, "no idle while quiet")
    `CHK(portBDataOut !== 36'h5_0a0a_0000, 1'b1, "word shown unread")
    for (r = 0; r < 2; r++) begin
      popB(3, 4);
      for (j = 0; j < 3; j++) `CHK(bbf_port_b_reader_i.got[j], 36'h5_0a0a_0000 + j, "word")
      {retransmitModeSelect, partialResetFifoOneN} = 2'h2;
      step(1);
      {retransmitModeSelect, partialResetFifoOneN} = 2'h1;
      step(6);
    end
    prs(1'b0);
  endtask

  // Fill until refused, then drain in order
  task automatic t_fill;
    integer j;
    integer acc;
    acc = 0;
    portAWriteEnable = 1'b1;
    for (j = 0; j < 24; j++) begin
      portADataBus = 36'h0_0000_0100 + j;
      if (portAFullInReady === 1'b1) acc++;
      step(1);
    end
    portAWriteEnable = 1'b0;
    step(4);
    `CHK(acc < 24, 1'b1, "never refused")
    `CHK(portAAlmostFullN, 1'b0, "almost full high")
    `CHK(portBAlmostEmptyN, 1'b1, "almost empty low")
    popB(16, 0);
    for (j = 0; j < 16; j++) `CHK(bbf_port_b_reader_i.got[j], 36'h0_0000_0100 + j, "order")
    step(4);
    `CHK(portAFullInReady, 1'b1, "no room after drain")
    `CHK(portBAlmostEmptyN, 1'b0, "almost empty high")
    prs(1'b0);
  endtask

  task automatic t_mail;
    portBSize = `BBF_SIZE_36;
    wrA(36'h9_8765_4321, 1'b1);
    `CHK(mailboxOneFlag, 1'b1, "mail one flag")
    portBMailSelect = 1'b1;
    step(1);
    `CHK(portBDataOut, 36'h9_8765_4321, "mail one data")
    portBMailSelect = 1'b0;
    wrB(36'h1_2345_6789, 1'b1);
    `CHK(mailboxTwoFlag, 1'b1, "mail two flag")
    portAMailSelect = 1'b1;
    step(1);
    `CHK(portADataOut, 36'h1_2345_6789, "mail two data")
    portAMailSelect = 1'b0;
  endtask

  // Narrow Port B pieces packed into one word, then a flush
  task automatic t_narrow(input logic be, input logic [1:0] size, input integer n);
    integer      k;
    integer      r;
    logic [35:0] ex;
    logic [35:0] v;
    mres(be);
    `CHK(mailboxTwoFlag, 1'b0, "mail flag kept")
    portBSize = size;
    for (r = 0; r < 2; r++) begin
      ex = 36'h0;
      for (k = 0; k < n; k++) begin
        v = (36'h0_0001_0203 * (k + 1)) & ((36'h1 << (36 / n)) - 36'h1);
        ex = be ? ((ex << (36 / n)) | v) : (ex | (v << ((36 / n) * k)));
        wrB(v, 1'b0);
      end
    end
    step(6);
    `CHK(portAEmptyOutReady, 1'b1, "fifo two not ready")
    `CHK(portBAlmostFullN, 1'b1, "B almost full")
    portAReadEnable = 1'b1;
    step(1);
    portAReadEnable = 1'b0;
    `CHK(portADataOut, ex, "pieces packed wrongly")
    prs(1'b1);
  endtask

  task automatic t_fall_through_mode;
    {portBSize, endianTimingModeSelect} = {`BBF_SIZE_36, 1'b1};
    wrA(36'h3_3333_3333, 1'b0);
    step(8);
    `CHK(portBEmptyOutReady, 1'b1, "no output ready")
    `CHK(portBDataOut, 36'h3_3333_3333, "no fall through")
    wrA(36'h4_4444_4444, 1'b0);
    step(8);
    `CHK(portBDataOut, 36'h3_3333_3333, "later word unread")
  endtask

  initial begin
    {num_errors, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
    {retransmitModeSelect, endianTimingModeSelect, paritySelect, serialOffsetInput} = 4'h0;
    {flagSelectBit0, flagSelectBit1, flagSelectBit2, offsetLoadEnable, start} = 5'h0;
    {portAWriteEnable, portAReadEnable, portAMailSelect, portBWriteEnable} = 4'h0;
    {portBMailSelect, portBSize, portADataBus, portBDataIn, count, gap} = 85'h0;
    {reset, masterResetOneN, masterResetTwoN, partialResetFifoOneN, partialResetFifoTwoN} = 5'h1f;
    step(3);
    reset = 1'b0;
    mres(1'b0);
    t_stdret;
    t_fill;
    t_mail;
    t_narrow(1'b1, `BBF_SIZE_18, 2);
    t_narrow(1'b0, `BBF_SIZE_9, 4);
    t_fall_through_mode;
    wrap_up;
  end
endmodule // bbf_bidir_fifo_tb
